//--- pkg/tmc_regs.vh
// Register map, field positions and constants of the 16-bit timer with compare triggers
`ifndef TMC_REGS_VH
`define TMC_REGS_VH
// Register indices; byte address is four times the index
`define TMC_IDX_FLAGS_ONE 8'h0c
`define TMC_IDX_FLAGS_TWO 8'h0d
`define TMC_IDX_COUNT_LO 8'h0e
`define TMC_IDX_COUNT_HI 8'h0f
`define TMC_IDX_CTRL 8'h10
`define TMC_IDX_CMP1_LO 8'h15
`define TMC_IDX_CMP1_HI 8'h16
`define TMC_IDX_CMP1_CTL 8'h17
`define TMC_IDX_CMP2_LO 8'h1b
`define TMC_IDX_CMP2_HI 8'h1c
`define TMC_IDX_CMP2_CTL 8'h1d
`define TMC_IDX_PORTC_DIR 8'h87
`define TMC_IDX_ENABLES_ONE 8'h8c
`define TMC_IDX_ENABLES_TWO 8'h8d
`define TMC_IDX_CMP3_LO 8'h95
`define TMC_IDX_CMP3_HI 8'h96
`define TMC_IDX_CMP3_CTL 8'h97
// Counter control fields
`define TMC_CTRL_ON 0
`define TMC_CTRL_SRC 1
`define TMC_CTRL_SYNC_N 2
`define TMC_CTRL_OSC_EN 3
`define TMC_CTRL_PS_LSB 4
`define TMC_CTRL_RUN 6
`define TMC_CTRL_WMASK 8'h3f
// Flag register fields
`define TMC_F1_OVF 0
`define TMC_F1_CMP1 2
`define TMC_F2_CMP2 0
`define TMC_F2_CMP3 1
`define TMC_F1_MASK 8'h05
`define TMC_F2_MASK 8'h03
// Compare control: mode field is low nibble, upper two bits unimplemented
`define TMC_CCTL_MASK 8'h3f
`define TMC_MODE_SET 4'h8
`define TMC_MODE_CLR 4'h9
`define TMC_MODE_SWI 4'ha
`define TMC_MODE_TRIG 4'hb
// Reset values
`define TMC_RST_ZERO 8'h00
`define TMC_RST_DIR 8'hff
// Compare one pin sits on port C bit 2
`define TMC_DIR_CMP1_BIT 2
`endif

//--- rtl/tmc_ripple_prescaler.v
// Asynchronous ripple prescaler clocked by the external count input
`timescale 1ns/1ps
module tmc_ripple_prescaler #(
  parameter STAGES = 3
) (
  input wire ext_clk,
  input wire presetn,
  input wire [1:0] sel,
  output reg div_out
);
  // Stage clocks: stage i toggles when stage i-1 falls
  wire [STAGES:0] stage_clk;
  // Ripple stage values
  wire [STAGES-1:0] stage_q;
  assign stage_clk[0] = ext_clk;
  genvar gi;
  ////////////////////////////////////////////////////////////////////
  generate
    for (gi = 0; gi < STAGES; gi = gi + 1) begin : g_stage
      reg bit_ff;
      always @(posedge stage_clk[gi] or negedge presetn) begin
        if (!presetn) begin
          bit_ff <= 1'b0;
        end else begin
          bit_ff <= ~bit_ff;
        end
      end
      assign stage_q[gi] = bit_ff;
      // Inverted so the next stage sees the falling edge as rising
      assign stage_clk[gi+1] = ~bit_ff;
    end
  endgenerate
  ////////////////////////////////////////////////////////////////////
  // Divided output select; division 1 passes the pin straight through
  always @* begin
    case (sel)
      2'd0: div_out = ext_clk;
      2'd1: div_out = stage_q[0];
      2'd2: div_out = stage_q[1];
      default: div_out = stage_q[2];
    endcase
  end
endmodule

//--- rtl/tmc_timer.v
// Top: 16-bit timer/counter with three compare channels and an APB register slave
`timescale 1ns/1ps
`include "tmc_regs.vh"
module tmc_timer (
  input wire pclk,
  input wire presetn,
  input wire clk_en,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [9:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire oscillator_input_pin,
  input wire external_count_pin,
  input wire sleep_mode,
  input wire adc_enabled,
  input wire system_clock_from_timer_osc,
  output reg [2:0] compare_out,
  output reg compare_one_oe,
  output reg adc_start,
  output reg irq
);
  ////////////////////////////////////////////////////////////////////
  // Register state
  reg [7:0] ctrl_ff;        // Counter control, low six bits writable
  reg [7:0] flags_one_ff;   // Overflow and channel one flags
  reg [7:0] flags_two_ff;   // Channel two and three flags
  reg [7:0] en_one_ff;      // Mask for flags_one
  reg [7:0] en_two_ff;      // Mask for flags_two
  reg [7:0] dir_ff;         // Port C direction
  reg [15:0] count_ff;      // Counter pair, no reset on purpose
  reg [15:0] cmp_val_ff [0:2]; // Compare values, no reset
  reg [7:0] cmp_ctl_ff [0:2];  // Compare controls
  reg [2:0] match_prev_ff;  // Match level of the previous cycle
  // Tick generation state
  reg [1:0] quarter_ff;     // Divides pclk by four
  reg [2:0] tpre_ff;        // Timer-mode prescaler
  reg sync1_ff;             // First synchroniser stage
  reg sync2_ff;             // Second synchroniser stage
  reg sync3_ff;             // Edge-detect history
  reg armed_ff;             // Falling edge seen since enable
  ////////////////////////////////////////////////////////////////////
  // Decoded controls
  wire cnt_on = ctrl_ff[`TMC_CTRL_ON];
  wire src_ext = ctrl_ff[`TMC_CTRL_SRC];
  wire sync_n = ctrl_ff[`TMC_CTRL_SYNC_N];
  wire osc_en = ctrl_ff[`TMC_CTRL_OSC_EN];
  wire [1:0] ps_sel = ctrl_ff[`TMC_CTRL_PS_LSB+1:`TMC_CTRL_PS_LSB];
  // APB phases
  wire setup = psel && !penable;
  wire wr_acc = psel && penable && pwrite && pready;
  wire [7:0] idx = paddr[9:2];
  wire [7:0] wdat = pwdata[7:0];
  ////////////////////////////////////////////////////////////////////
  // external pin select
  wire ext_in = osc_en ? oscillator_input_pin : external_count_pin;
  // Prescaled external input, still in the pin's own timing
  wire ext_div;
  tmc_ripple_prescaler #(
    .STAGES(3)
  ) u_pre (
    .ext_clk(ext_in),
    .presetn(presetn),
    .sel(ps_sel),
    .div_out(ext_div)
  );
  ////////////////////////////////////////////////////////////////////
  // sync after prescaler
  // Both counter modes must be sampled here since the block has one clock;
  // the unsynchronised mode differs only in that it keeps counting in sleep.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_ff <= 1'b0;
      sync2_ff <= 1'b0;
      sync3_ff <= 1'b0;
    end else if (clk_en) begin
      sync1_ff <= ext_div;
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
    end
  end
  // Edge flags last one pclk each; the pin must hold each level for
  // at least two cycles or an edge can slip between samples.
  wire ext_rise = sync2_ff && !sync3_ff;
  wire ext_fall = !sync2_ff && sync3_ff;
  ////////////////////////////////////////////////////////////////////
  // arm on falling edge
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      armed_ff <= 1'b0;
    end else if (clk_en) begin
      if (!cnt_on || !src_ext) begin
        // Disarm whenever the counter is off or in timer mode
        armed_ff <= 1'b0;
      end else if (ext_fall) begin
        // First falling edge after enable arms the counter
        armed_ff <= 1'b1;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////
  // quarter-rate timer tick
  // The internal prescaler mirrors the ripple one so both modes divide alike.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      quarter_ff <= 2'b00;
      tpre_ff <= 3'b000;
    end else if (clk_en) begin
      quarter_ff <= quarter_ff + 2'b01;
      if (quarter_ff == 2'b11 && cnt_on && !src_ext) begin
        tpre_ff <= tpre_ff + 3'b001;
      end
    end
  end
  // Mask of prescaler bits that must be all ones for a tick
  reg [2:0] pre_mask;
  always @* begin
    case (ps_sel)
      2'd0: pre_mask = 3'b000;
      2'd1: pre_mask = 3'b001;
      2'd2: pre_mask = 3'b011;
      default: pre_mask = 3'b111;
    endcase
  end
  // Tick on the last quarter step once the selected prescaler bits are all ones
  wire tmr_tick = (quarter_ff == 2'b11) && ((tpre_ff & pre_mask) == pre_mask);
  wire ext_ok = ext_rise && armed_ff && !(sleep_mode && !sync_n);
  wire tick = cnt_on && (src_ext ? ext_ok : tmr_tick);
  ////////////////////////////////////////////////////////////////////
  // equality compare
  wire [2:0] match_lvl;
  wire [2:0] match_hit;
  wire [2:0] trig_hit;
  genvar ch;
  generate
    for (ch = 0; ch < 3; ch = ch + 1) begin : g_cmp
      assign match_lvl[ch] = (count_ff == cmp_val_ff[ch]);
      // Only the first cycle of equality counts, so a held count fires once
      assign match_hit[ch] = match_lvl[ch] && !match_prev_ff[ch];
      assign trig_hit[ch] = match_hit[ch] && (cmp_ctl_ff[ch][3:0] == `TMC_MODE_TRIG);
    end
  endgenerate
  // trigger clears pair
  // Channel three has no counter reset; its trigger only raises its flag.
  wire trig_reset = trig_hit[0] || trig_hit[1];
  // Software write strobes of the count bytes
  wire wr_lo = wr_acc && (idx == `TMC_IDX_COUNT_LO);
  wire wr_hi = wr_acc && (idx == `TMC_IDX_COUNT_HI);
  wire ovf = tick && (count_ff == 16'hffff) && !trig_reset && !wr_lo && !wr_hi;
  ////////////////////////////////////////////////////////////////////
  // counter without reset
  // A power-on reset leaves the pair as it was; software writes win over counting.
  always @(posedge pclk) begin
    if (clk_en) begin
      if (wr_lo || wr_hi) begin
        if (wr_lo) begin
          count_ff[7:0] <= wdat;
        end
        if (wr_hi) begin
          count_ff[15:8] <= wdat;
        end
      end else if (trig_reset) begin
        // Trigger clear beats a tick so the programmed period is exact
        count_ff <= 16'h0000;
      end else if (tick) begin
        count_ff <= count_ff + 16'h0001;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////
  // Compare values hold no reset value either
  always @(posedge pclk) begin
    if (clk_en && wr_acc) begin
      case (idx)
        `TMC_IDX_CMP1_LO: cmp_val_ff[0][7:0] <= wdat;
        `TMC_IDX_CMP1_HI: cmp_val_ff[0][15:8] <= wdat;
        `TMC_IDX_CMP2_LO: cmp_val_ff[1][7:0] <= wdat;
        `TMC_IDX_CMP2_HI: cmp_val_ff[1][15:8] <= wdat;
        `TMC_IDX_CMP3_LO: cmp_val_ff[2][7:0] <= wdat;
        `TMC_IDX_CMP3_HI: cmp_val_ff[2][15:8] <= wdat;
        // Other indices leave the compare values alone
        default: cmp_val_ff[0] <= cmp_val_ff[0];
      endcase
    end
  end
  ////////////////////////////////////////////////////////////////////
  // Event sources for the flags
  wire [2:0] cmp_evt;
  generate
    for (ch = 0; ch < 3; ch = ch + 1) begin : g_evt
      assign cmp_evt[ch] = match_hit[ch] && cmp_ctl_ff[ch][3];
    end
  endgenerate
  // Write-one-to-clear masks; a new event in the same cycle keeps its flag
  wire [7:0] clr_one = (wr_acc && idx == `TMC_IDX_FLAGS_ONE) ? wdat : 8'h00;
  wire [7:0] clr_two = (wr_acc && idx == `TMC_IDX_FLAGS_TWO) ? wdat : 8'h00;
  wire [7:0] set_one = {5'b00000, cmp_evt[0], 1'b0, ovf};
  wire [7:0] set_two = {6'b000000, cmp_evt[2], cmp_evt[1]};
  // Next flag values: set wins over clear
  wire [7:0] nxt_flags_one = ((flags_one_ff & ~clr_one) | set_one) & `TMC_F1_MASK;
  wire [7:0] nxt_flags_two = ((flags_two_ff & ~clr_two) | set_two) & `TMC_F2_MASK;
  ////////////////////////////////////////////////////////////////////
  // Next mask values, so irq moves at the same edge as a mask write
  // and a masked interrupt never lingers for an extra cycle.
  wire en_one_wr = wr_acc && (idx == `TMC_IDX_ENABLES_ONE);
  wire en_two_wr = wr_acc && (idx == `TMC_IDX_ENABLES_TWO);
  wire [7:0] nxt_en_one = en_one_wr ? (wdat & `TMC_F1_MASK) : en_one_ff;
  wire [7:0] nxt_en_two = en_two_wr ? (wdat & `TMC_F2_MASK) : en_two_ff;
  ////////////////////////////////////////////////////////////////////
  // Control, mask and flag registers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= `TMC_RST_ZERO;
      flags_one_ff <= `TMC_RST_ZERO;
      flags_two_ff <= `TMC_RST_ZERO;
      en_one_ff <= `TMC_RST_ZERO;
      en_two_ff <= `TMC_RST_ZERO;
      dir_ff <= `TMC_RST_DIR;
      cmp_ctl_ff[0] <= `TMC_RST_ZERO;
      cmp_ctl_ff[1] <= `TMC_RST_ZERO;
      cmp_ctl_ff[2] <= `TMC_RST_ZERO;
      match_prev_ff <= 3'b000;
    end else if (clk_en) begin
      flags_one_ff <= nxt_flags_one;
      flags_two_ff <= nxt_flags_two;
      // Remember this cycle's match levels for first-cycle detection
      match_prev_ff <= match_lvl;
      if (wr_acc) begin
        case (idx)
          `TMC_IDX_CTRL: ctrl_ff <= wdat & `TMC_CTRL_WMASK;
          `TMC_IDX_ENABLES_ONE: en_one_ff <= wdat & `TMC_F1_MASK;
          `TMC_IDX_ENABLES_TWO: en_two_ff <= wdat & `TMC_F2_MASK;
          `TMC_IDX_PORTC_DIR: dir_ff <= wdat;
          `TMC_IDX_CMP1_CTL: cmp_ctl_ff[0] <= wdat & `TMC_CCTL_MASK;
          `TMC_IDX_CMP2_CTL: cmp_ctl_ff[1] <= wdat & `TMC_CCTL_MASK;
          `TMC_IDX_CMP3_CTL: cmp_ctl_ff[2] <= wdat & `TMC_CCTL_MASK;
          // Flag registers change only through the set and clear masks above
          default: ctrl_ff <= ctrl_ff;
        endcase
      end
    end
  end
  ////////////////////////////////////////////////////////////////////
  // Compare output latches, separate from any port data latch
  generate
    for (ch = 0; ch < 3; ch = ch + 1) begin : g_out
      wire ctl_wr = wr_acc && (idx == (ch == 0 ? `TMC_IDX_CMP1_CTL :
                    (ch == 1 ? `TMC_IDX_CMP2_CTL : `TMC_IDX_CMP3_CTL)));
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          compare_out[ch] <= 1'b0;
        end else if (clk_en) begin
          if (ctl_wr && (wdat & `TMC_CCTL_MASK) == 8'h00) begin
            compare_out[ch] <= 1'b0;
          end else if (match_hit[ch]) begin
            // interrupt and trigger modes leave the latch alone
            case (cmp_ctl_ff[ch][3:0])
              `TMC_MODE_SET: compare_out[ch] <= 1'b1;
              `TMC_MODE_CLR: compare_out[ch] <= 1'b0;
              default: compare_out[ch] <= compare_out[ch];
            endcase
          end
        end
      end
    end
  endgenerate
  ////////////////////////////////////////////////////////////////////
  // Pin enable, conversion start and interrupt outputs
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      compare_one_oe <= 1'b0;
      adc_start <= 1'b0;
      irq <= 1'b0;
    end else if (clk_en) begin
      compare_one_oe <= !dir_ff[`TMC_DIR_CMP1_BIT];
      adc_start <= trig_hit[1] && adc_enabled;
      // Level interrupt from next flags and next masks, so it follows
      // a flag clear or a mask write at the very edge that takes it
      irq <= |(nxt_flags_one & nxt_en_one) || |(nxt_flags_two & nxt_en_two);
    end
  end
  ////////////////////////////////////////////////////////////////////
  // Read multiplexer; the run flag reflects the live clock-source input
  reg [7:0] rd_byte;
  reg rd_hit;
  always @* begin
    rd_hit = 1'b1;
    case (idx)
      `TMC_IDX_FLAGS_ONE: rd_byte = flags_one_ff;
      `TMC_IDX_FLAGS_TWO: rd_byte = flags_two_ff;
      `TMC_IDX_COUNT_LO: rd_byte = count_ff[7:0];
      `TMC_IDX_COUNT_HI: rd_byte = count_ff[15:8];
      // Top control bit is unimplemented and reads as zero
      `TMC_IDX_CTRL: rd_byte = {1'b0, system_clock_from_timer_osc, ctrl_ff[5:0]};
      `TMC_IDX_CMP1_LO: rd_byte = cmp_val_ff[0][7:0];
      `TMC_IDX_CMP1_HI: rd_byte = cmp_val_ff[0][15:8];
      `TMC_IDX_CMP1_CTL: rd_byte = cmp_ctl_ff[0];
      `TMC_IDX_CMP2_LO: rd_byte = cmp_val_ff[1][7:0];
      `TMC_IDX_CMP2_HI: rd_byte = cmp_val_ff[1][15:8];
      `TMC_IDX_CMP2_CTL: rd_byte = cmp_ctl_ff[1];
      `TMC_IDX_PORTC_DIR: rd_byte = dir_ff;
      `TMC_IDX_ENABLES_ONE: rd_byte = en_one_ff;
      `TMC_IDX_ENABLES_TWO: rd_byte = en_two_ff;
      `TMC_IDX_CMP3_LO: rd_byte = cmp_val_ff[2][7:0];
      `TMC_IDX_CMP3_HI: rd_byte = cmp_val_ff[2][15:8];
      `TMC_IDX_CMP3_CTL: rd_byte = cmp_ctl_ff[2];
      default: begin
        rd_byte = 8'h00;
        rd_hit = 1'b0;
      end
    endcase
  end
  ////////////////////////////////////////////////////////////////////
  // APB slave: one wait-free access; data and ready are set up during setup
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (clk_en) begin
      pready <= setup;
      // Unmapped indices answer with an error; writes there change nothing
      pslverr <= setup && !rd_hit;
      // Read data captured in setup and held until the next read
      if (setup && !pwrite) begin
        prdata <= {24'h000000, rd_byte};
      end
    end
  end
endmodule

//--- bench/tmc_timer_asserts.sv
// Port-level assertions for the timer with compare triggers
`timescale 1ns/1ps
module tmc_timer_asserts (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [9:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic oscillator_input_pin,
  input wire logic external_count_pin,
  input wire logic sleep_mode,
  input wire logic adc_enabled,
  input wire logic system_clock_from_timer_osc,
  input wire logic [2:0] compare_out,
  input wire logic compare_one_oe,
  input wire logic adc_start,
  input wire logic irq
);
  // Completed write, the only moment a register is written
  wire wr_acc;
  // Shadow of the channel one mode, rebuilt from bus writes
  logic [3:0] mode1_ff;
  logic [3:0] nxt_mode1;
  assign wr_acc = psel && penable && pready && pwrite;
  default clocking dcb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////////
  // Mode shadow follows writes to the channel one control
  always @* begin
    nxt_mode1 = (wr_acc && paddr == 10'h05c) ? pwdata[3:0] : mode1_ff;
  end
  // Reset to a mode with no effect so nothing fires before setup
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode1_ff <= 4'h0;
    end else begin
      mode1_ff <= nxt_mode1;
    end
  end
  ////////////////////////////////////////////////////////////////
  sequence s_setup;
    psel && !penable && clk_en;
  endsequence
  sequence s_dir_wr;
    wr_acc && paddr == 10'h21c;
  endsequence
  sequence s_ctl1_zero;
    wr_acc && paddr == 10'h05c && pwdata[7:0] == 8'h00;
  endsequence
  a_ready_after_setup: assert property (s_setup |=> pready && penable)
    else $error("no ready in the access cycle");
  a_ready_in_access: assert property (pready |-> psel && penable)
    else $error("ready outside an access");
  a_err_needs_ready: assert property (pslverr |-> pready)
    else $error("error flag without ready");
  a_oe_follows_dir: assert property (s_dir_wr |-> ##2 compare_one_oe == !$past(pwdata[2], 2))
    else $error("output enable does not follow direction bit");
  a_zero_ctl_low: assert property (s_ctl1_zero |-> ##[1:2] !compare_out[0])
    else $error("zero control write left output high");
  a_swi_pin_kept: assert property (mode1_ff == 4'ha && $past(mode1_ff) == 4'ha |-> $stable(compare_out[0]))
    else $error("software interrupt mode moved the output");
  a_adc_gated: assert property (adc_start |-> adc_enabled || $past(adc_enabled))
    else $error("conversion start while converter disabled");
  a_adc_one_cycle: assert property (adc_start |=> !adc_start)
    else $error("conversion start longer than one cycle");
  a_irq_falls_on_write: assert property ($fell(irq) |-> $past(wr_acc))
    else $error("interrupt dropped without a register write");
endmodule
bind tmc_timer tmc_timer_asserts u_tmc_timer_asserts (.pclk(pclk), .presetn(presetn),
  .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .oscillator_input_pin(oscillator_input_pin), .external_count_pin(external_count_pin),
  .sleep_mode(sleep_mode), .adc_enabled(adc_enabled),
  .system_clock_from_timer_osc(system_clock_from_timer_osc), .compare_out(compare_out),
  .compare_one_oe(compare_one_oe), .adc_start(adc_start), .irq(irq));

//--- bench/tmc_count_src.sv
// Model of the external source that drives the two count pins
`timescale 1ns/1ps
module tmc_count_src (
  input wire logic pclk,
  input wire logic use_osc,
  output logic oscillator_input_pin,
  output logic external_count_pin
);
  // Both pins rest low, so the first edge after enable is a rise
  initial begin
    oscillator_input_pin = 1'b0;
    external_count_pin = 1'b0;
  end
  // Pulse train; half of two or more cycles keeps the synchroniser happy
  task automatic pulses(input int n, input int half);
    repeat (n) begin
      drive(1'b1);
      repeat (half) @(posedge pclk);
      drive(1'b0);
      repeat (half) @(posedge pclk);
    end
  endtask
  // Only the selected pin moves; the other stays quiet
  task automatic drive(input logic v);
    if (use_osc) oscillator_input_pin <= v;
    else external_count_pin <= v;
  endtask
endmodule

//--- bench/sixteen_bit_timer_compare_trigger_test.sv
// Self-checking bench for the 16-bit timer with compare triggers
`timescale 1ns/1ps
`include "tmc_regs.vh"
module sixteen_bit_timer_compare_trigger_test;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [9:0] paddr = 10'h000;
  logic [31:0] pwdata = 32'h0;
  logic sleep_mode = 1'b0, adc_enabled = 1'b0, sys_osc = 1'b0, use_osc = 1'b0, clk_en = 1'b1;
  logic [7:0] rd, v;
  logic last_err, seen;
  wire [31:0] prdata;
  wire pready, pslverr, osc_pin, ext_pin, cmp1_oe, adc_start, irq;
  wire [2:0] compare_out;
  int error_cnt = 0, compares = 0, cyc = 0, i, k, ex;
  // Counter-mode cases: control, pin, sleep, expected count
  logic [7:0] c_ctl [5] = '{8'h03, 8'h0b, 8'h0b, 8'h03, 8'h07};
  logic c_osc [5] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
  logic c_slp [5] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
  int c_exp [5] = '{5, 5, 0, 0, 5};
  // Reset table and free read/write registers
  logic [7:0] r_idx [$] = '{8'h0c, 8'h0d, 8'h10, 8'h17, 8'h1d, 8'h97, 8'h87, 8'h8c, 8'h8d};
  logic [7:0] r_val [$] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'h00, 8'h00};
  logic [7:0] rw_idx [$] = '{8'h0e, 8'h0f, 8'h15, 8'h16, 8'h1b, 8'h1c, 8'h95, 8'h96};
  // Compare modes tried on all three channels and the output each leaves
  logic [7:0] m_val [3] = '{8'h09, 8'h08, 8'h0a};
  logic m_out [3] = '{1'b0, 1'b1, 1'b1};
  tmc_timer u_tmc_timer (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .oscillator_input_pin(osc_pin),
    .external_count_pin(ext_pin), .sleep_mode(sleep_mode), .adc_enabled(adc_enabled),
    .system_clock_from_timer_osc(sys_osc), .compare_out(compare_out),
    .compare_one_oe(cmp1_oe), .adc_start(adc_start), .irq(irq));
  tmc_count_src u_tmc_count_src (.pclk(pclk), .use_osc(use_osc),
    .oscillator_input_pin(osc_pin), .external_count_pin(ext_pin));
  ////////////////////////////////////////////////////////////////
  // 25 MHz clock
  always #20 pclk = ~pclk;
  // Whole run is a few thousand cycles; the ceiling leaves wide margin
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 60000) begin
      error_cnt++;
      final_report();
    end
  end
  task automatic check(input logic [31:0] seen_v, input logic [31:0] exp_v);
    compares++;
    if (seen_v !== exp_v) begin
      error_cnt++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen_v, exp_v);
    end
  endtask
  // One APB transfer, entered just after an edge; an idle edge follows
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
    int w;
    w = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h0, wd};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      w++;
    end while (pready !== 1'b1 && w < 50);
    if (w >= 50) begin
      error_cnt++;
      final_report();
    end
    rd = prdata[7:0];
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d);
  endtask
  task automatic rdchk(input logic [7:0] idx, input logic [7:0] e);
    apb(1'b0, idx, 8'h00);
    check(32'(rd), 32'(e));
  endtask
  task automatic tdone(input int n);
    $display("test %0d done", n);
  endtask
  task automatic final_report;
    $display("compares=%0d mismatches=%0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(96));
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // Reset values, unmapped slot, random read-back, masked bits
    foreach (r_idx[i]) rdchk(r_idx[i], r_val[i]);
    apb(1'b0, 8'h0b, 8'h00);
    check({23'h0, last_err, rd}, 32'h100);
    foreach (rw_idx[i]) begin
      v = 8'($urandom);
      wr(rw_idx[i], v);
      rdchk(rw_idx[i], v);
    end
    sys_osc <= 1'b1;
    wr(8'h97, 8'hff);
    rdchk(8'h97, 8'h3f);
    wr(8'h10, 8'hfe);
    rdchk(8'h10, 8'h7e);
    wr(8'h97, 8'h00);
    wr(8'h10, 8'h00);
    tdone(1);
    // Quarter-clock rate for each prescale, about 402 cycles run
    for (k = 0; k < 4; k++) begin
      wr(8'h0e, 8'h00);
      wr(8'h0f, 8'h00);
      wr(8'h10, {2'b00, 2'(k), 4'h1});
      repeat (400) @(posedge pclk);
      wr(8'h10, 8'h00);
      apb(1'b0, 8'h0e, 8'h00);
      ex = 100 >> k;
      check(32'(rd >= ex - 1 && rd <= ex + 1), 32'h1);
    end
    // Overflow sets the flag; interrupt raised, masked and cleared
    wr(8'h8c, 8'h01);
    wr(8'h0e, 8'hfe);
    wr(8'h0f, 8'hff);
    wr(8'h10, 8'h01);
    repeat (40) @(posedge pclk);
    wr(8'h10, 8'h00);
    check(32'(irq), 32'h1);
    rdchk(8'h0c, 8'h01);
    rdchk(8'h0f, 8'h00);
    apb(1'b0, 8'h0e, 8'h00);
    v = rd;
    repeat (20) @(posedge pclk);
    rdchk(8'h0e, v);
    // Clock enable low freezes the running counter: at most one tick
    wr(8'h0e, 8'h00);
    wr(8'h0f, 8'h00);
    wr(8'h10, 8'h01);
    clk_en <= 1'b0;
    repeat (200) @(posedge pclk);
    clk_en <= 1'b1;
    wr(8'h10, 8'h00);
    apb(1'b0, 8'h0e, 8'h00);
    check(32'(rd <= 8'h01), 32'h1);
    wr(8'h8c, 8'h00);
    check(32'(irq), 32'h0);
    wr(8'h8c, 8'h05);
    check(32'(irq), 32'h1);
    wr(8'h0c, 8'h01);
    check(32'(irq), 32'h0);
    tdone(2);
    // Channel one trigger gives a period of 0x10; no overflow flag
    wr(8'h15, 8'h10);
    wr(8'h16, 8'h00);
    wr(8'h17, 8'h0b);
    wr(8'h10, 8'h01);
    repeat (300) @(posedge pclk);
    wr(8'h10, 8'h00);
    rdchk(8'h0f, 8'h00);
    apb(1'b0, 8'h0e, 8'h00);
    check(32'(rd <= 8'h10), 32'h1);
    rdchk(8'h0c, 8'h04);
    wr(8'h0c, 8'h04);
    wr(8'h17, 8'h00);
    tdone(3);
    // Channel two trigger starts a conversion only when enabled
    for (k = 0; k < 2; k++) begin
      adc_enabled <= k[0] ^ 1'b1;
      wr(8'h0e, 8'h00);
      wr(8'h0f, 8'h00);
      wr(8'h1b, 8'h08);
      wr(8'h1c, 8'h00);
      wr(8'h1d, 8'h0b);
      wr(8'h10, 8'h01);
      seen = 1'b0;
      repeat (100) begin
        @(posedge pclk);
        if (adc_start === 1'b1) seen = 1'b1;
      end
      wr(8'h10, 8'h00);
      check(32'(seen), 32'(k == 0));
      rdchk(8'h0d, 8'h01);
      rdchk(8'h0c, 8'h00);
      wr(8'h0d, 8'h01);
      wr(8'h1d, 8'h00);
    end
    tdone(4);
    // Clear, set and software modes, then a zero control write
    wr(8'h87, 8'hfb);
    // The enable follows the direction one edge after the write
    @(posedge pclk);
    check(32'(cmp1_oe), 32'h1);
    for (k = 0; k < 3; k++) begin
      wr(8'h0e, 8'h00);
      wr(8'h0f, 8'h00);
      wr(8'h15, 8'h05);
      wr(8'h16, 8'h00);
      wr(8'h17, m_val[k]);
      wr(8'h1b, 8'h05);
      wr(8'h1c, 8'h00);
      wr(8'h1d, m_val[k]);
      wr(8'h95, 8'h05);
      wr(8'h96, 8'h00);
      wr(8'h97, m_val[k]);
      wr(8'h10, 8'h01);
      repeat (60) @(posedge pclk);
      wr(8'h10, 8'h00);
      check(32'(compare_out), 32'({3{m_out[k]}}));
      rdchk(8'h0c, 8'h04);
      rdchk(8'h0d, 8'h03);
      wr(8'h0c, 8'h04);
      wr(8'h0d, 8'h03);
    end
    wr(8'h17, 8'h00);
    check(32'(compare_out[0]), 32'h0);
    tdone(5);
    // Counter mode: pin choice, first-fall arming, sleep behaviour
    for (k = 0; k < 5; k++) begin
      wr(8'h0e, 8'h00);
      wr(8'h0f, 8'h00);
      use_osc <= c_osc[k];
      sleep_mode <= c_slp[k];
      wr(8'h10, c_ctl[k]);
      u_tmc_count_src.pulses(6, 3 + 2 * (k % 2));
      repeat (10) @(posedge pclk);
      sleep_mode <= 1'b0;
      wr(8'h10, 8'h00);
      rdchk(8'h0e, 8'(c_exp[k]));
    end
    tdone(6);
    final_report();
  end
endmodule
